/* oss_osc_select.sv */
// Behaviour
// RQ1: At reset the pick field chooses HF 1 MHz, HF 32 MHz, LF, or external clock.
// RQ2: Current source indicator reads back the reset source pick value.
// RQ3: External clocks of 16 MHz and up use high power, slower use low power.
// RQ4: Disable bit 0 drives instruction clock on its pin; 1 leaves pin as I/O.
// RQ5: Internal modes leave the external clock pin and output pin free for I/O; the code frees the output pin only when the disable bit is 1.
// RQ6: External clock runs with no start-up delay after reset or wake-up.
// RQ7: Stopped external clock halts everything intact; restart resumes where it stopped.
// RQ8: Trim is six-bit two's complement, zero means nominal frequency.
// RQ9: Positive trim 0x01 to 0x1F raises the high-frequency oscillator.
// RQ10: Negative trim 0x3F to 0x20 lowers the high-frequency oscillator.
// RQ11: Trim changes frequency gradually while running, with no status shown.
// RQ12: Trim leaves the low-frequency oscillator untouched.
// RQ13: Mid-frequency source gives fixed 500 kHz and 31.25 kHz regardless of setting.
// RQ14: Mid-frequency clocks feed peripherals only, never the system clock.
// RQ15: Low-frequency oscillator gives a fixed nominal 31 kHz clock.
// RQ16: High-frequency oscillator frequency follows the frequency choice register.
// RQ17: Converter RC oscillator clocks only the converter, never the system.
// RQ18: Low-frequency oscillator is also the power-up and watchdog time base.
// RQ19: Source selection happens only at reset, no switching at run time.
`timescale 1ns/1ps
`default_nettype none
`include "oss_params.svh"

module oss_osc_select
  import oss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Configuration straps
  input  wire logic [1:0]  reset_source_pick,
  input  wire logic        external_type_pick,
  input  wire logic        clock_output_disable_n,
  // External clock pin
  input  wire logic        external_clock_in,
  output var  logic        ext_pin_free,
  // Instruction clock pin and its port logic
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output var  logic        instruction_clock_out,
  output var  logic        instruction_clock_oe,
  // Clock strobes
  output var  logic        sys_clk_en,
  output var  logic        instr_clk_en,
  output var  logic        lf_tick,
  output var  logic        mf_500k_tick,
  output var  logic        mf_31k_tick,
  output var  logic        adc_rc_tick,
  // Status
  output var  logic [1:0]  current_source_indicator,
  output var  logic        ext_high_power_mode,
  output var  logic        osc_running,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest
);

  // ****************************************
  // Declarations
  // ****************************************
  oss_state_t  state;
  oss_state_t  next_state;
  oss_src_t    src;
  logic [3:0]  strap_s1;
  logic [3:0]  strap_s2;
  logic [3:0]  strap_s3;
  logic [1:0]  fill;
  logic        strap_ok;
  logic        out_dis;
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_s3;
  logic        ext_lvl;
  logic        ext_rise;
  logic        hf_tick;
  logic        hf1_tick;
  logic [3:0]  post_cnt;
  logic        next_sys;
  logic [1:0]  phase;
  logic [2:0]  hf_frequency_bits;
  logic [5:0]  hf_trim_value;
  logic        ack;
  logic        req;
  logic [31:0] status_word;
  logic [1:0]  chk_cnt;

  assign osc_running = (state == OSS_ST_RUN);

  // ****************************************
  // Strap capture
  // ****************************************

  // Straps come from outside the clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
      strap_s3 <= 4'h0;
    end else begin
      strap_s1 <= {clock_output_disable_n, external_type_pick, reset_source_pick};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  assign strap_ok = (strap_s2 == strap_s3);

  // Wait until the synchroniser is filled before trusting it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill <= 2'h0;
    end else if (fill != 2'h3) begin
      fill <= fill + 2'h1;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      OSS_ST_IDLE:    if (fill == 2'h3) next_state = OSS_ST_CAPTURE;
      OSS_ST_CAPTURE: if (strap_ok) next_state = OSS_ST_RUN;
      OSS_ST_RUN:     next_state = OSS_ST_RUN;
      default:        next_state = OSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= OSS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Source is latched once per reset, never switched later
  always_ff @(posedge clk or negedge rst_b) begin // RQ19
    if (!rst_b) begin
      src                 <= OSS_SRC_HF32;
      ext_high_power_mode <= 1'b0;
      out_dis             <= 1'b1;
    end else if (state == OSS_ST_CAPTURE && strap_ok) begin
      src                 <= oss_src_t'(strap_s3[1:0]); // RQ1
      ext_high_power_mode <= strap_s3[2]; // RQ3
      out_dis             <= strap_s3[3];
    end
  end

  assign current_source_indicator = src; // RQ2

  // ****************************************
  // Oscillators
  // ****************************************

  oss_nco u_hf (
    .clk               (clk),
    .rst_b             (rst_b),
    .run               (osc_running),
    .hf_frequency_bits (hf_frequency_bits),
    .hf_trim_value     (hf_trim_value),
    .hf_tick           (hf_tick)
  );

  // Low-frequency clock has its own divider, out of reach of trim
  oss_divider #(.DIV(`OSS_LF_DIV)) u_lf ( // RQ12
    .clk   (clk),
    .rst_b (rst_b),
    .run   (osc_running),
    .tick  (lf_tick)
  ); // RQ15 RQ18

  // Mid-frequency clocks come from the fixed reference, not the tuned NCO
  oss_divider #(.DIV(`OSS_MF_HI_DIV)) u_mf_hi (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (osc_running),
    .tick  (mf_500k_tick)
  ); // RQ13

  oss_divider #(.DIV(`OSS_MF_LO_DIV)) u_mf_lo (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (osc_running),
    .tick  (mf_31k_tick)
  ); // RQ13

  // Converter clock leaves the block on its own strobe only
  oss_divider #(.DIV(`OSS_ADC_RC_DIV)) u_adc_rc (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (osc_running),
    .tick  (adc_rc_tick)
  ); // RQ17

  // Post divider gives 1 MHz from the 16 MHz reset setting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      post_cnt <= 4'h0;
    end else if (hf_tick) begin
      post_cnt <= post_cnt + 4'h1;
    end
  end

  assign hf1_tick = hf_tick && (post_cnt == `OSS_HF1_POSTDIV);

  // ****************************************
  // External clock
  // ****************************************

  // Three flops; an edge counts once the last two agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      ext_lvl <= 1'b0;
    end else begin
      ext_s1 <= external_clock_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_lvl <= ext_s3;
      end
    end
  end

  assign ext_rise = (ext_s2 == ext_s3) && ext_s3 && !ext_lvl;

  // ****************************************
  // System and instruction clock
  // ****************************************

  // Mid-frequency strobes are deliberately absent from this mux
  always_comb begin // RQ14
    next_sys = 1'b0;
    if (osc_running) begin
      unique case (src)
        OSS_SRC_HF32: next_sys = hf_tick;
        OSS_SRC_LF:   next_sys = lf_tick;
        OSS_SRC_HF1:  next_sys = hf1_tick;
        OSS_SRC_EXT:  next_sys = ext_rise; // RQ6 RQ7
      endcase
    end
  end

  // Everything downstream advances only on this strobe, so a stalled clock freezes it
  always_ff @(posedge clk or negedge rst_b) begin // RQ7
    if (!rst_b) begin
      sys_clk_en   <= 1'b0;
      instr_clk_en <= 1'b0;
      phase        <= 2'h0;
    end else begin
      sys_clk_en   <= next_sys;
      instr_clk_en <= sys_clk_en && (phase == 2'h3);
      if (sys_clk_en) begin
        phase <= phase + 2'h1;
      end
    end
  end

  // Output pin carries the divide-by-four square or the port logic
  always_ff @(posedge clk or negedge rst_b) begin // RQ4
    if (!rst_b) begin
      instruction_clock_out <= 1'b0;
      instruction_clock_oe  <= 1'b0;
    end else if (osc_running && !out_dis) begin
      instruction_clock_out <= phase[1];
      instruction_clock_oe  <= 1'b1;
    end else begin
      instruction_clock_out <= gpio_out;
      instruction_clock_oe  <= gpio_oe;
    end
  end

  // Input pin is free once running, unless it is the clock source
  assign ext_pin_free = osc_running && (src != OSS_SRC_EXT); // RQ5

  // ****************************************
  // Register bus
  // ****************************************
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;

  // One wait cycle per access, then release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // Frequency choice takes its reset value from the picked source
  always_ff @(posedge clk or negedge rst_b) begin // RQ16
    if (!rst_b) begin
      hf_frequency_bits <= `OSS_FREQ_RST_HF1;
    end else if (state == OSS_ST_CAPTURE && strap_ok) begin
      hf_frequency_bits <= (strap_s3[1:0] == OSS_SRC_HF32) ? `OSS_FREQ_RST_HF32 : `OSS_FREQ_RST_HF1;
    end else if (ack && avs_write && avs_byteenable[0] && avs_address == `OSS_ADDR_FREQ) begin
      hf_frequency_bits <= avs_writedata[2:0];
    end
  end

  // Trim register, two's complement
  always_ff @(posedge clk or negedge rst_b) begin // RQ8
    if (!rst_b) begin
      hf_trim_value <= `OSS_TRIM_RST;
    end else if (ack && avs_write && avs_byteenable[0] && avs_address == `OSS_ADDR_TRIM) begin
      hf_trim_value <= avs_writedata[5:0];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`OSS_ST_SRC_LSB +: 2] = src;
    status_word[`OSS_ST_EXT_HP]       = ext_high_power_mode;
    status_word[`OSS_ST_OUT_DIS]      = out_dis;
    status_word[`OSS_ST_RUN]          = osc_running;
  end

  // Read data stands with the released wait; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        `OSS_ADDR_STATUS: avs_readdata <= status_word;
        `OSS_ADDR_FREQ:   avs_readdata <= {29'h0000_0000, hf_frequency_bits};
        `OSS_ADDR_TRIM:   avs_readdata <= {26'h000_0000, hf_trim_value};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Helper: system strobes since the last instruction strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_cnt <= 2'h0;
    end else if (sys_clk_en) begin
      chk_cnt <= chk_cnt + 2'h1;
    end
  end

  // Indicator must carry the pick that the synchroniser held at capture
  property p_src_mirror;
    $rose(osc_running) |-> (current_source_indicator == oss_src_t'($past(strap_s3[1:0])));
  endproperty
  a_src_mirror: assert property (p_src_mirror) else $error("indicator differs from source"); // RQ2

  property p_src_fixed;
    osc_running && $past(osc_running) |-> $stable(src);
  endproperty
  a_src_fixed: assert property (p_src_fixed) else $error("source changed at run time"); // RQ19

  property p_pin_clock;
    osc_running && !out_dis |=> instruction_clock_oe && (instruction_clock_out == $past(phase[1]));
  endproperty
  a_pin_clock: assert property (p_pin_clock) else $error("instruction clock not on pin"); // RQ4

  property p_pin_gpio;
    out_dis |=> (instruction_clock_oe == $past(gpio_oe)) && (instruction_clock_out == $past(gpio_out));
  endproperty
  a_pin_gpio: assert property (p_pin_gpio) else $error("pin not released to port logic"); // RQ4

  property p_div_four;
    instr_clk_en |-> $past(chk_cnt) == 2'h3 && $past(sys_clk_en);
  endproperty
  a_div_four: assert property (p_div_four) else $error("instruction clock not a quarter rate"); // RQ4

  property p_ext_follow;
    osc_running && src == OSS_SRC_EXT |-> ##1 (sys_clk_en == $past(ext_rise));
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("system clock not tracking external edge"); // RQ7

  property p_lf_sys;
    osc_running && src == OSS_SRC_LF |=> (sys_clk_en == $past(lf_tick));
  endproperty
  a_lf_sys: assert property (p_lf_sys) else $error("low-frequency source not on system clock"); // RQ15

  property p_freq_reset;
    $rose(osc_running) |-> hf_frequency_bits ==
      ((src == OSS_SRC_HF32) ? `OSS_FREQ_RST_HF32 : `OSS_FREQ_RST_HF1);
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("frequency choice reset value wrong"); // RQ1

  sequence s_bus_wait;
    req && !ack && avs_waitrequest;
  endsequence
  sequence s_bus_done;
    !avs_waitrequest && ack;
  endsequence
  property p_bus;
    s_bus_wait |=> s_bus_done;
  endproperty
  a_bus: assert property (p_bus) else $error("bus access not answered after one wait"); // RQ8

  property p_trim_store;
    ack && avs_write && avs_byteenable[0] && avs_address == `OSS_ADDR_TRIM
      |=> hf_trim_value == $past(avs_writedata[5:0]);
  endproperty
  a_trim_store: assert property (p_trim_store) else $error("trim write lost"); // RQ8

endmodule : oss_osc_select

`default_nettype wire

/* oss_params.svh */
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH

// ****************************************
// Clock rates
// ****************************************
`define OSS_REF_HZ        40000000
`define OSS_LF_HZ         31000
`define OSS_MF_HI_HZ      500000
`define OSS_MF_LO_HZ      31250
`define OSS_ADC_RC_HZ     600000

// Divider counts derived from the 40 MHz reference, rounded down
`define OSS_LF_DIV        (`OSS_REF_HZ / `OSS_LF_HZ)
`define OSS_MF_HI_DIV     (`OSS_REF_HZ / `OSS_MF_HI_HZ)
`define OSS_MF_LO_DIV     (`OSS_REF_HZ / `OSS_MF_LO_HZ)
`define OSS_ADC_RC_DIV    (`OSS_REF_HZ / `OSS_ADC_RC_HZ)

// ****************************************
// Oscillator model constants
// ****************************************
`define OSS_NCO_STEP_1MHZ 24'(((64'd1 << 24) * 64'd1000000) / 64'(`OSS_REF_HZ))
`define OSS_FREQ_MAX      3'h5
`define OSS_TRIM_SHIFT    9
`define OSS_SLEW_LAST     10'h3ff
`define OSS_HF1_POSTDIV   4'hf

// ****************************************
// Register byte offsets
// ****************************************
`define OSS_ADDR_STATUS   4'h0
`define OSS_ADDR_FREQ     4'h4
`define OSS_ADDR_TRIM     4'h8

// ****************************************
// Field positions
// ****************************************
`define OSS_ST_SRC_LSB    0
`define OSS_ST_EXT_HP     2
`define OSS_ST_OUT_DIS    3
`define OSS_ST_RUN        4

// ****************************************
// Reset values
// ****************************************
`define OSS_FREQ_RST_HF1  3'h4
`define OSS_FREQ_RST_HF32 3'h5
`define OSS_TRIM_RST      6'h00

`endif

/* oss_pkg.sv */
package oss_pkg;

  // Start-up sequencer, Gray along idle, capture, run
  typedef enum logic [1:0] {
    OSS_ST_IDLE    = 2'b00,
    OSS_ST_CAPTURE = 2'b01,
    OSS_ST_RUN     = 2'b11
  } oss_state_t;

  // Reset source pick encodings
  typedef enum logic [1:0] {
    OSS_SRC_HF32 = 2'b00,
    OSS_SRC_LF   = 2'b01,
    OSS_SRC_HF1  = 2'b10,
    OSS_SRC_EXT  = 2'b11
  } oss_src_t;

endpackage : oss_pkg

/* oss_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oss_params.svh"

module oss_divider #(
  parameter int unsigned DIV = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control and output
  input  wire logic run,
  output var  logic tick
);

  localparam logic [15:0] LAST = 16'(DIV - 1);

  logic [15:0] cnt;

  // Free count, one pulse per period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt  <= (cnt == LAST) ? 16'h0000 : cnt + 16'h0001;
    end
  end

endmodule : oss_divider

`default_nettype wire

/* oss_nco.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oss_params.svh"

module oss_nco (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Setting
  input  wire logic       run,
  input  wire logic [2:0] hf_frequency_bits,
  input  wire logic [5:0] hf_trim_value,
  // Output
  output var  logic       hf_tick
);

  logic [23:0] acc;
  logic [24:0] acc_sum;
  logic [5:0]  trim_eff;
  logic [9:0]  slew_cnt;

  // Phase step for a frequency code plus signed trim
  function automatic logic [23:0] oss_hf_step(input logic [2:0] code,
                                               input logic [5:0] trim);
    logic [2:0]         c;
    logic [23:0]        nom;
    logic signed [25:0] unit;
    logic signed [25:0] tr;
    logic signed [25:0] sum;
    c    = (code > `OSS_FREQ_MAX) ? `OSS_FREQ_MAX : code;
    nom  = `OSS_NCO_STEP_1MHZ << c;
    unit = $signed(26'(nom >> `OSS_TRIM_SHIFT));
    tr   = $signed({{20{trim[5]}}, trim});
    sum  = $signed({2'b00, nom}) + 26'(tr * unit);
    return sum[23:0];
  endfunction : oss_hf_step

  assign acc_sum = {1'b0, acc} + {1'b0, oss_hf_step(hf_frequency_bits, trim_eff)};

  // Accumulator, carry is the oscillator edge
  always_ff @(posedge clk or negedge rst_b) begin // RQ16
    if (!rst_b) begin
      acc     <= 24'h000000;
      hf_tick <= 1'b0;
    end else begin
      acc     <= acc_sum[23:0];
      hf_tick <= run & acc_sum[24];
    end
  end

  // Trim walks one step at a time, no status of the walk
  always_ff @(posedge clk or negedge rst_b) begin // RQ11
    if (!rst_b) begin
      slew_cnt <= 10'h000;
      trim_eff <= `OSS_TRIM_RST;
    end else begin
      slew_cnt <= slew_cnt + 10'h001;
      if (slew_cnt == `OSS_SLEW_LAST) begin
        if ($signed(trim_eff) < $signed(hf_trim_value)) begin // RQ9
          trim_eff <= trim_eff + 6'h01;
        end else if ($signed(trim_eff) > $signed(hf_trim_value)) begin // RQ10
          trim_eff <= trim_eff - 6'h01;
        end
      end
    end
  end

  // Effective trim never jumps
  property p_trim_slew;
    @(posedge clk) disable iff (!rst_b)
    $changed(trim_eff) |-> ($past(slew_cnt) == `OSS_SLEW_LAST) &&
      ((trim_eff - $past(trim_eff) == 6'h01) || ($past(trim_eff) - trim_eff == 6'h01));
  endproperty
  a_trim_slew: assert property (p_trim_slew) else $error("trim moved by more than one step"); // RQ11

endmodule : oss_nco

`default_nettype wire

/* oss_ext_clk_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External logic-level clock generator
// ****************************************
module oss_ext_clk_model #(
  parameter int HALF_NS = 97
) (
  // Control from the bench
  input  wire logic run,
  // Clock pin
  output var  logic ext_clk
);
  // Odd half period keeps edges off the 25 ns grid; stands low when stopped
  initial begin
    ext_clk = 1'b0;
    forever begin
      #(HALF_NS);
      ext_clk = run ? ~ext_clk : 1'b0;
    end
  end
endmodule : oss_ext_clk_model
`default_nettype wire

/* tb_oscillator_source_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oss_params.svh"
module tb_oscillator_source_select;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'b0, rst_b = 1'b0, ext_run = 1'b1, gpio_out = 1'b0, gpio_oe = 1'b0;
  logic [1:0]  reset_source_pick = 2'h0;
  logic        external_type_pick = 1'b0, clock_output_disable_n = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        external_clock_in, ext_pin_free, instruction_clock_out, instruction_clock_oe, sys_clk_en;
  logic        instr_clk_en, lf_tick, mf_500k_tick, mf_31k_tick, adc_rc_tick, ext_high_power_mode;
  logic        osc_running, avs_waitrequest;
  logic [1:0]  current_source_indicator;
  int          miscompares = 0, n_checks = 0, cyc = 0, cnt[7];
  int          lo[4] = '{3198, 3, 99, 508};
  int          hi[4] = '{3201, 4, 101, 520};

  oss_osc_select dut_u (.clk, .rst_b, .reset_source_pick, .external_type_pick, .clock_output_disable_n,
    .external_clock_in, .ext_pin_free, .gpio_out, .gpio_oe, .instruction_clock_out, .instruction_clock_oe,
    .sys_clk_en, .instr_clk_en, .lf_tick, .mf_500k_tick, .mf_31k_tick, .adc_rc_tick, .current_source_indicator,
    .ext_high_power_mode, .osc_running, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  oss_ext_clk_model ext_u (.run(ext_run), .ext_clk(external_clock_in));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict;
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int l, input int h);
    n_checks++;
    if (got < l || got > h) begin
      miscompares++;
      $display("Error t=%0t count %0d outside %0d..%0d", $time, got, l, h);
    end
  endtask : chk_rng

  // One bus access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk_rng(n, 1, 1);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Straps are only taken at reset, so every mode needs its own reset
  task automatic do_reset(input logic [1:0] pick, input logic dis);
    int n;
    n = 0;
    rst_b <= 1'b0;
    reset_source_pick <= pick;
    clock_output_disable_n <= dis;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    while (osc_running !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(osc_running, 32'h1);
  endtask : do_reset

  task automatic rates(input int w, input int l, input int h);
    logic prev;
    cnt = '{default: 0};
    prev = instruction_clock_out;
    repeat (w) begin
      @(posedge clk);
      cnt[0] += int'(sys_clk_en === 1'b1);
      cnt[1] += int'(instr_clk_en === 1'b1);
      cnt[2] += int'(lf_tick === 1'b1);
      cnt[3] += int'(mf_500k_tick === 1'b1);
      cnt[4] += int'(adc_rc_tick === 1'b1);
      cnt[6] += int'(mf_31k_tick === 1'b1);
      cnt[5] += int'(instruction_clock_out !== prev);
      prev = instruction_clock_out;
    end
    chk_rng(cnt[0], l, h);
    chk_rng(cnt[1], l / 4 - 1, h / 4 + 1);
    chk_rng(cnt[2], w / 1290, w / 1290 + 1);
    chk_rng(cnt[3], w / 80, w / 80 + 1);
    chk_rng(cnt[4], w / 66, w / 66 + 1);
    chk_rng(cnt[6], w / 1280, w / 1280 + 1);
  endtask : rates

  // Hang guard, well above the expected 45k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int n;
    // Every reset pick, pin handed to port logic
    for (int p = 0; p < 4; p++) begin
      gpio_oe <= p[0];
      gpio_out <= p[1];
      // Power pick only matters for an external source, so an internal run may carry either
      external_type_pick <= (p == 1);
      do_reset(2'(p), 1'b1);
      reset_source_pick <= 2'(3 - p);
      bus(1'b0, `OSS_ADDR_STATUS, 32'h0);
      chk(rd, 32'h18 | 32'(p) | ((p == 1) ? 32'h4 : 32'h0));
      chk(current_source_indicator, 32'(p));
      chk(ext_pin_free, 32'(p != 3));
      chk(instruction_clock_oe, 32'(p[0]));
      chk(instruction_clock_out, 32'(p[1]));
      chk(ext_high_power_mode, 32'(p == 1));
      bus(1'b0, `OSS_ADDR_TRIM, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `OSS_ADDR_FREQ, 32'h0);
      chk(rd, (p == 0) ? 32'h5 : 32'h4);
      rates(4000, lo[p], hi[p]);
      chk_rng(cnt[5], 0, 0);
      chk(current_source_indicator, 32'(p));
    end
    // Instruction clock on its pin, 8 MHz from the 32 MHz source
    do_reset(2'h0, 1'b0);
    rates(4000, 3198, 3201);
    chk(instruction_clock_oe, 32'h1);
    chk_rng(cnt[5], 2 * cnt[1] - 2, 2 * cnt[1] + 2);
    // Trim up one step, then down two steps to one below nominal
    bus(1'b1, `OSS_ADDR_TRIM, 32'h1);
    bus(1'b0, `OSS_ADDR_TRIM, 32'h0);
    chk(rd, 32'h1);
    repeat (1100) @(posedge clk);
    rates(4000, 3203, 3210);
    bus(1'b0, `OSS_ADDR_STATUS, 32'h0);
    chk(rd, 32'h10);
    bus(1'b1, `OSS_ADDR_TRIM, 32'h3f);
    bus(1'b1, `OSS_ADDR_TRIM, 32'h05, 4'he);
    bus(1'b1, `OSS_ADDR_STATUS, 32'h3);
    bus(1'b0, `OSS_ADDR_TRIM, 32'h0);
    chk(rd, 32'h3f);
    bus(1'b0, `OSS_ADDR_STATUS, 32'h0);
    chk(rd, 32'h10);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    repeat (2200) @(posedge clk);
    rates(4000, 3190, 3197);
    // Frequency choice to 8 MHz, mid clocks unmoved
    bus(1'b1, `OSS_ADDR_FREQ, 32'h3);
    bus(1'b0, `OSS_ADDR_FREQ, 32'h0);
    chk(rd, 32'h3);
    rates(4000, 795, 800);
    // Codes above the top setting act as the top setting
    bus(1'b1, `OSS_ADDR_FREQ, 32'h7);
    rates(4000, 3190, 3197);
    // External clock: prompt start, halt and resume with state kept
    external_type_pick <= 1'b0;
    do_reset(2'h3, 1'b1);
    n = 0;
    while (sys_clk_en !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk_rng(n, 0, 16);
    bus(1'b1, `OSS_ADDR_TRIM, 32'h15);
    ext_run <= 1'b0;
    repeat (20) @(posedge clk);
    rates(2000, 0, 0);
    bus(1'b0, `OSS_ADDR_TRIM, 32'h0);
    chk(rd, 32'h15);
    ext_run <= 1'b1;
    rates(4000, 508, 520);
    print_verdict();
  end
endmodule : tb_oscillator_source_select
`default_nettype wire
